// ### stk_host_model.sv
// Host bus master model that runs SRAM-style strobe cycles on data line 0.
module stk_host_model
	import stk_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic dev_data_i,
	input  wire logic dev_oe_n_i,
	output logic      chip_en_n_o,
	output logic      out_en_n_o,
	output logic      wr_en_n_o,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Key bytes listed last-sent first (the rightmost C5 goes first), each one shifted out from its lowest bit.
	localparam logic [63:0] KEY = {8'h5C, 8'hA3, 8'h3A, 8'hC5, 8'h5C, 8'hA3, 8'h3A, 8'hC5};

	logic drv_q;
	logic dat_q;
	logic last_q;

	// With nobody driving and no pull, the line shows the inverse of its last driven level.
	assign line_o = !dev_oe_n_i ? dev_data_i : (drv_q ? dat_q : ~last_q);

	initial begin
		chip_en_n_o = 1'b1;
		out_en_n_o  = 1'b1;
		wr_en_n_o   = 1'b1;
		drv_q       = 1'b0;
		dat_q       = 1'b0;
		last_q      = 1'b0;
	end

	// Only a driven level is remembered, so a released line stays put instead of toggling.
	always @(posedge clk_sys_i) begin
		if (drv_q || !dev_oe_n_i) begin
			last_q <= line_o;
		end
	end

	// ---------------------------------------------------------------
	// Bus cycles
	// ---------------------------------------------------------------
	// Strobes stand 8 clocks so the pin filters see them; data outlives the strobe.
	task automatic cyc(input logic wr, input logic d, output logic q, output logic drove);
		@(posedge clk_sys_i);
		chip_en_n_o <= 1'b0;
		out_en_n_o  <= wr;
		wr_en_n_o   <= ~wr;
		drv_q       <= wr;
		dat_q       <= d;
		repeat (7) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		q = line_o;
		drove = ~dev_oe_n_i;
		@(posedge clk_sys_i);
		chip_en_n_o <= 1'b1;
		out_en_n_o  <= 1'b1;
		wr_en_n_o   <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		drv_q <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask

	task automatic unlock(input int bad_at);
		logic q;
		logic dv;
		cyc(1'b0, 1'b0, q, dv);
		for (int i = 0; i < 64; i++) cyc(1'b1, KEY[i] ^ (i == bad_at), q, dv);
	endtask

	// Bit k of the packed words is bit k%8 of register k/8, always all 64 in order.
	task automatic xfer(input logic wr, input logic [63:0] wb, output logic [63:0] rb, output logic [63:0] dr);
		for (int k = 0; k < 64; k++) cyc(wr, wb[k], rb[k], dr[k]);
	endtask
endmodule

// ### stk_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
module stk_pin_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lv_q;
			always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_q <= INIT[g];
					s2_q <= INIT[g];
					s3_q <= INIT[g];
					lv_q <= INIT[g];
				end else begin
					s1_q <= pin_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// A change counts only once the last two stages agree.
					if (s2_q == s3_q) begin
						lv_q <= s3_q;
					end
				end
			end
			assign level_o[g] = lv_q;
		end
	endgenerate

endmodule

// ### stk_pkg.sv
// Constants, register layout and types shared by the serial timekeeper.
package stk_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 40;
	localparam int TICK_PERIOD_NS = 10_000_000;
	localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Access key and transfer length
	// ---------------------------------------------------------------
	localparam logic [63:0] KEY_PATTERN = 64'h5CA33AC55CA33AC5;
	localparam logic [5:0]  LAST_BIT    = 6'h3F;
	localparam logic [2:0]  LAST_IN_BYTE = 3'h7;

	// ---------------------------------------------------------------
	// Register indices and field positions
	// ---------------------------------------------------------------
	localparam int REG_HUND  = 0;
	localparam int REG_SEC   = 1;
	localparam int REG_MIN   = 2;
	localparam int REG_HOUR  = 3;
	localparam int REG_DAY   = 4;
	localparam int REG_DATE  = 5;
	localparam int REG_MONTH = 6;
	localparam int REG_YEAR  = 7;
	localparam int HR_MODE_BIT  = 7;
	localparam int HR_PM_BIT    = 5;
	localparam int DAY_MASK_BIT = 4;
	localparam int DAY_HALT_BIT = 5;

	// Bits that hold data; the rest always read zero.
	localparam logic [7:0] REG_MASK [8] = '{8'hFF, 8'h7F, 8'h7F, 8'hBF,
		8'h37, 8'h3F, 8'h1F, 8'hFF};

	// Values after reset: halt and reset mask set, 1st day, 1 Jan 00.
	localparam logic [7:0] REG_RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h31, 8'h01, 8'h01, 8'h00};

	// ---------------------------------------------------------------
	// Access sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_XFER = 2'b01,
		ST_MISS = 2'b10
	} stk_state_t;

endpackage

// ### stk_timekeeper.sv
// Serial timekeeper behind SRAM strobes: key match, bit-serial access, BCD clock.
module stk_timekeeper
	import stk_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic chip_en_n_i,
	input  wire logic out_en_n_i,
	input  wire logic wr_en_n_i,
	input  wire logic ext_rst_n_i,
	input  wire logic serial_data_line_i,
	output logic      serial_data_line_o,
	output logic      serial_data_line_oe_n_o,
	output logic      mem_inhibit_o
);

	// ---------------------------------------------------------------
	// Pin synchronisation and cycle detection
	// ---------------------------------------------------------------
	logic [4:0] pins_s;
	logic       ce_n;
	logic       oe_n;
	logic       we_n;
	logic       xrst_n;
	logic       din;
	logic       wr_act;
	logic       rd_act;
	logic       wr_act_q;
	logic       rd_act_q;
	logic       wr_end;
	logic       rd_end;
	logic       bit_q;

	stk_pin_sync #(
		.W    (5),
		.INIT (5'h1F)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.pin_i     ({serial_data_line_i, ext_rst_n_i, wr_en_n_i, out_en_n_i, chip_en_n_i}),
		.level_o   (pins_s)
	);

	assign ce_n   = pins_s[0];
	assign oe_n   = pins_s[1];
	assign we_n   = pins_s[2];
	assign xrst_n = pins_s[3];
	assign din    = pins_s[4];
	assign wr_act = !ce_n && !we_n;
	assign rd_act = !ce_n && !oe_n && we_n;
	assign wr_end = wr_act_q && !wr_act;
	assign rd_end = rd_act_q && !rd_act;

	// The data bit is taken at the close of the write, when it is settled.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			bit_q    <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			if (wr_act) begin
				bit_q <= din;
			end
		end
	end

	// ---------------------------------------------------------------
	// Register storage and control bits
	// ---------------------------------------------------------------
	logic [7:0] tk_q [8];
	logic [7:0] nxt  [8];
	logic       halt;
	logic       rmask;
	logic       abort;

	assign halt  = tk_q[REG_DAY][DAY_HALT_BIT];
	assign rmask = tk_q[REG_DAY][DAY_MASK_BIT];
	assign abort = !xrst_n && !rmask;

	// ---------------------------------------------------------------
	// Key recognition and transfer sequencing
	// ---------------------------------------------------------------
	stk_state_t st_q;
	logic [5:0] kptr_q;
	logic [5:0] cnt_q;
	logic [7:0] wsh_q;
	logic [63:0] shad_q;
	logic [63:0] live;
	logic        xfer;
	logic        commit;
	logic [7:0]  wbyte;
	logic        key_done;

	assign xfer     = (st_q == ST_XFER);
	assign key_done = wr_end && (st_q == ST_HUNT) && !abort && (kptr_q == LAST_BIT)
		&& (bit_q == KEY_PATTERN[kptr_q]);
	assign wbyte    = {bit_q, wsh_q[7:1]};
	assign commit   = wr_end && xfer && !abort && (cnt_q[2:0] == LAST_IN_BYTE);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q   <= ST_HUNT;
			kptr_q <= 6'h00;
		end else if (abort) begin
			st_q   <= ST_HUNT;
			kptr_q <= 6'h00;
		end else if (rd_end && !xfer) begin
			st_q   <= ST_HUNT;
			kptr_q <= 6'h00;
		end else if (wr_end) begin
			case (st_q)
				ST_HUNT: begin
					// Key bits arrive LSB first, byte after byte.
					if (bit_q == KEY_PATTERN[kptr_q]) begin
						if (kptr_q == LAST_BIT) begin
							st_q   <= ST_XFER;
							kptr_q <= 6'h00;
						end else begin
							kptr_q <= kptr_q + 6'h01;
						end
					end else begin
						st_q <= ST_MISS;
					end
				end
				ST_XFER: begin
					if (cnt_q == LAST_BIT) begin
						st_q <= ST_HUNT;
					end
				end
				default: begin
					st_q <= st_q;
				end
			endcase
		end else if (rd_end && xfer && cnt_q == LAST_BIT) begin
			st_q <= ST_HUNT;
		end
	end

	// Bit position within the transfer, bit 0 of register 0 first.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 6'h00;
		end else if (abort || !xfer) begin
			cnt_q <= 6'h00;
		end else if (wr_end || rd_end) begin
			cnt_q <= cnt_q + 6'h01;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wsh_q <= 8'h00;
		end else if (wr_end && xfer) begin
			wsh_q <= wbyte;
		end
	end

	// Reads come from a copy taken at key match, so a tick during the
	// transfer cannot tear a value across registers.
	always_comb begin
		live = 64'h0;
		for (int i = 0; i < 8; i++) begin
			live[i*8 +: 8] = tk_q[i];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shad_q <= 64'h0;
		end else if (key_done) begin
			shad_q <= live;
		end
	end

	// ---------------------------------------------------------------
	// Serial line drive and memory inhibit
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_data_line_o      <= 1'b0;
			serial_data_line_oe_n_o <= 1'b1;
		end else begin
			serial_data_line_o      <= shad_q[cnt_q];
			serial_data_line_oe_n_o <= !(xfer && rd_act && !abort);
		end
	end

	assign mem_inhibit_o = xfer;

	// ---------------------------------------------------------------
	// Hundredths timebase
	// ---------------------------------------------------------------
	logic [31:0] pre_q;
	logic        tick_q;
	logic        pend_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (halt) begin
			pre_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (pre_q == TICK_CYCLES - 1) begin
			pre_q  <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			pre_q  <= pre_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// A tick that meets a register write waits one cycle rather than
	// being lost; a new tick wins over the clear of the pending flag.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= tick_q || (pend_q && commit);
		end
	end

	// ---------------------------------------------------------------
	// BCD calendar carry chain
	// ---------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Leap test on the two-digit year; tens*10 mod 4 equals 2*tens[0].
	function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
		logic [3:0] lp;
		lp = yr[3:0] + {2'b00, yr[4], 1'b0};
		case (mo)
			8'h02: month_len = (lp[1:0] == 2'b00) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction

	logic c_sec;
	logic c_min;
	logic c_hr;
	logic c_day;
	logic c_mon;
	logic c_yr;
	logic [7:0] hr12_inc;
	logic [7:0] hr24_inc;

	assign hr12_inc = bcd_inc({3'b000, tk_q[REG_HOUR][4:0]});
	assign hr24_inc = bcd_inc({2'b00, tk_q[REG_HOUR][5:0]});

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			nxt[i] = tk_q[i];
		end
		c_sec = tk_q[REG_HUND] == 8'h99;
		c_min = c_sec && tk_q[REG_SEC] == 8'h59;
		c_hr  = c_min && tk_q[REG_MIN] == 8'h59;
		c_day = 1'b0;
		nxt[REG_HUND] = c_sec ? 8'h00 : bcd_inc(tk_q[REG_HUND]);
		if (c_sec) begin
			nxt[REG_SEC] = (tk_q[REG_SEC] == 8'h59) ? 8'h00 : bcd_inc(tk_q[REG_SEC]);
		end
		if (c_min) begin
			nxt[REG_MIN] = (tk_q[REG_MIN] == 8'h59) ? 8'h00 : bcd_inc(tk_q[REG_MIN]);
		end
		if (c_hr) begin
			if (tk_q[REG_HOUR][HR_MODE_BIT]) begin
				if (tk_q[REG_HOUR][4:0] == 5'h12) begin
					nxt[REG_HOUR][4:0] = 5'h01;
				end else if (tk_q[REG_HOUR][4:0] == 5'h11) begin
					nxt[REG_HOUR][4:0]       = 5'h12;
					nxt[REG_HOUR][HR_PM_BIT] = !tk_q[REG_HOUR][HR_PM_BIT];
					c_day = tk_q[REG_HOUR][HR_PM_BIT];
				end else begin
					nxt[REG_HOUR][4:0] = hr12_inc[4:0];
				end
			end else begin
				// Bits 5:4 form the tens digit in 24-hour counting.
				if (tk_q[REG_HOUR][5:0] == 6'h23) begin
					nxt[REG_HOUR][5:0] = 6'h00;
					c_day = 1'b1;
				end else begin
					nxt[REG_HOUR][5:0] = hr24_inc[5:0];
				end
			end
		end
		c_mon = c_day && tk_q[REG_DATE] == month_len(tk_q[REG_MONTH], tk_q[REG_YEAR]);
		c_yr  = c_mon && tk_q[REG_MONTH] == 8'h12;
		if (c_day) begin
			nxt[REG_DAY][2:0] = (tk_q[REG_DAY][2:0] == 3'h7) ? 3'h1 : tk_q[REG_DAY][2:0] + 3'h1;
			nxt[REG_DATE] = c_mon ? 8'h01 : bcd_inc(tk_q[REG_DATE]);
		end
		if (c_mon) begin
			nxt[REG_MONTH] = c_yr ? 8'h01 : bcd_inc(tk_q[REG_MONTH]);
		end
		if (c_yr) begin
			nxt[REG_YEAR] = (tk_q[REG_YEAR] == 8'h99) ? 8'h00 : bcd_inc(tk_q[REG_YEAR]);
		end
	end

	// ---------------------------------------------------------------
	// Register update: whole-byte writes, then pending ticks
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++) begin
				tk_q[i] <= REG_RST[i];
			end
		end else if (commit) begin
			// Unused positions are dropped here, so they always read zero.
			tk_q[cnt_q[5:3]] <= wbyte & REG_MASK[cnt_q[5:3]];
		end else if (pend_q && !halt) begin
			for (int i = 0; i < 8; i++) begin
				tk_q[i] <= nxt[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_read_resets_key;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rd_end && !xfer |=> kptr_q == 6'h00 && st_q == ST_HUNT;
	endproperty
	a_read_resets_key: assert property (p_read_resets_key)
		else $error("key pointer not reset by read cycle");

	property p_miss_freezes;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		st_q == ST_MISS && !rd_end && !abort |=> st_q == ST_MISS && $stable(kptr_q);
	endproperty
	a_miss_freezes: assert property (p_miss_freezes)
		else $error("key pointer moved after mismatch");

	property p_key_opens;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		wr_end && st_q == ST_HUNT && !abort && kptr_q == LAST_BIT && bit_q == KEY_PATTERN[63]
		|=> xfer && cnt_q == 6'h00 ##0 $past(live) == shad_q;
	endproperty
	a_key_opens: assert property (p_key_opens)
		else $error("full key match did not open transfer");

	property p_xfer_ends;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		xfer && (wr_end || rd_end) && cnt_q == LAST_BIT && !abort |=> !xfer && !mem_inhibit_o;
	endproperty
	a_xfer_ends: assert property (p_xfer_ends)
		else $error("transfer did not end after 64 cycles");

	property p_abort;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!xrst_n && !rmask |=> !xfer && kptr_q == 6'h00 && ($past(live) == live || $past(pend_q));
	endproperty
	a_abort: assert property (p_abort)
		else $error("reset pin did not abort transfer cleanly");

	property p_masked_pin;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		rmask && xfer && !wr_end && !rd_end |=> xfer && $stable(cnt_q);
	endproperty
	a_masked_pin: assert property (p_masked_pin)
		else $error("masked reset pin disturbed transfer");

	property p_zero_bits;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(live & ~{REG_MASK[7], REG_MASK[6], REG_MASK[5], REG_MASK[4],
			REG_MASK[3], REG_MASK[2], REG_MASK[1], REG_MASK[0]}) == 64'h0;
	endproperty
	a_zero_bits: assert property (p_zero_bits)
		else $error("unused register bit reads one");

	property p_halt_stops;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		halt && !commit |=> $stable(tk_q[REG_HUND]) && pre_q == 32'h0;
	endproperty
	a_halt_stops: assert property (p_halt_stops)
		else $error("counters advanced while halted");

	property p_pm_toggle;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!commit && pend_q && !halt && c_hr && tk_q[REG_HOUR][HR_MODE_BIT]
		&& tk_q[REG_HOUR][4:0] == 5'h11
		|=> tk_q[REG_HOUR][4:0] == 5'h12
		&& tk_q[REG_HOUR][HR_PM_BIT] != $past(tk_q[REG_HOUR][HR_PM_BIT]);
	endproperty
	a_pm_toggle: assert property (p_pm_toggle)
		else $error("hour 11 did not roll to 12 with the PM flag toggled");

	property p_hour24;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!commit && pend_q && !halt && c_hr && tk_q[REG_HOUR] == 8'h23
		|=> tk_q[REG_HOUR] == 8'h00 && tk_q[REG_HUND] == 8'h00;
	endproperty
	a_hour24: assert property (p_hour24)
		else $error("23h did not roll to 00h");

endmodule

// ### stk_timekeeper_tb.sv
// Self-checking testbench for the serial timekeeper.
module stk_timekeeper_tb
	import stk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [63:0] RST_EXP  = {8'h00, 8'h01, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [63:0] MASK_IN  = {8'hFF, 8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [63:0] MASK_EXP = {8'hFF, 8'h1F, 8'h3F, 8'h27, 8'hBF, 8'h7F, 8'h7F, 8'hFF};
	localparam logic [63:0] CASE_IN [2] = '{{8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59, 8'h99},
		{8'h04, 8'h02, 8'h28, 8'h03, 8'hB1, 8'h59, 8'h59, 8'h99}};
	localparam logic [63:0] CASE_EXP [2] = '{{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00},
		{8'h04, 8'h02, 8'h29, 8'h04, 8'h92, 8'h00, 8'h00, 8'h00}};

	logic clk_sys_i;
	logic rst_n_i;
	logic ext_rst_n;
	logic chip_en_n;
	logic out_en_n;
	logic wr_en_n;
	logic line;
	logic data_o;
	logic oe_n_o;
	logic mem_inhibit_o;
	int   err_count;
	int   checks;

	stk_timekeeper #(.TICK_CYCLES(4000)) stk_timekeeper_inst (
		.clk_sys_i              (clk_sys_i),
		.rst_n_i                (rst_n_i),
		.chip_en_n_i            (chip_en_n),
		.out_en_n_i             (out_en_n),
		.wr_en_n_i              (wr_en_n),
		.ext_rst_n_i            (ext_rst_n),
		.serial_data_line_i     (line),
		.serial_data_line_o     (data_o),
		.serial_data_line_oe_n_o(oe_n_o),
		.mem_inhibit_o          (mem_inhibit_o)
	);

	stk_host_model stk_host_model_inst (
		.clk_sys_i  (clk_sys_i),
		.dev_data_i (data_o),
		.dev_oe_n_i (oe_n_o),
		.chip_en_n_o(chip_en_n),
		.out_en_n_o (out_en_n),
		.wr_en_n_o  (wr_en_n),
		.line_o     (line)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// ---------------------------------------------------------------
	// Checking and access tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic rd_all(input logic [63:0] exp);
		logic [63:0] rb;
		logic [63:0] dr;
		stk_host_model_inst.unlock(-1);
		check(64'(mem_inhibit_o), 64'h1);
		stk_host_model_inst.xfer(1'b0, 64'h0, rb, dr);
		check(dr, {64{1'b1}});
		check(rb, exp);
		check(64'(mem_inhibit_o), 64'h0);
	endtask

	task automatic wr_all(input logic [63:0] wb);
		logic [63:0] rb;
		logic [63:0] dr;
		stk_host_model_inst.unlock(-1);
		stk_host_model_inst.xfer(1'b1, wb, rb, dr);
		check(dr, 64'h0);
	endtask

	// Pulses the external reset eight bits into a read transfer.
	task automatic rst_probe(input logic [63:0] exp, input logic open);
		logic q;
		logic dv;
		stk_host_model_inst.unlock(-1);
		for (int i = 0; i < 8; i++) stk_host_model_inst.cyc(1'b0, 1'b0, q, dv);
		@(posedge clk_sys_i);
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		ext_rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		check(64'(mem_inhibit_o), 64'(open));
		if (open) for (int i = 8; i < 64; i++) stk_host_model_inst.cyc(1'b0, 1'b0, q, dv);
		check(64'(mem_inhibit_o), 64'h0);
		rd_all(exp);
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys_i);
		err_count++;
		tally_and_finish();
	end

	initial begin
		logic q;
		logic dv;
		err_count = 0;
		checks    = 0;
		rst_n_i   = 1'b0;
		ext_rst_n = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		rd_all(RST_EXP);
		rst_probe(RST_EXP, 1'b1);
		// A broken key must leave the transfer window shut, and the next read, made in the miss state, undriven.
		stk_host_model_inst.unlock(37);
		check(64'(mem_inhibit_o), 64'h0);
		stk_host_model_inst.cyc(1'b0, 1'b0, q, dv);
		check(64'(dv), 64'h0);
		for (int c = 0; c < 2; c++) begin
			// In the second pass the first write halts the running clock so the second lands exactly.
			repeat (c + 1) wr_all(MASK_IN);
			rd_all(MASK_EXP);
			if (c == 0) rst_probe(MASK_EXP, 1'b0);
			wr_all(CASE_IN[c]);
			repeat (4000) @(posedge clk_sys_i);
			rd_all(CASE_EXP[c]);
		end
		tally_and_finish();
	end
endmodule
